// File: rtl/pcb_regs.svh
// Bus command codes and address-phase field layout for the bridge decoder.
// Assumes a 32-bit multiplexed address/data bus with active-low command lines.
`ifndef PCB_REGS_SVH
`define PCB_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes (true polarity, cbe_n inverted)
// ----------------------------------------------------------------------------
`define PCB_CMD_INTACK   4'h0
`define PCB_CMD_SPECIAL  4'h1
`define PCB_CMD_IO_RD    4'h2
`define PCB_CMD_IO_WR    4'h3
`define PCB_CMD_RSV4     4'h4
`define PCB_CMD_RSV5     4'h5
`define PCB_CMD_MEM_RD   4'h6
`define PCB_CMD_MEM_WR   4'h7
`define PCB_CMD_RSV8     4'h8
`define PCB_CMD_RSV9     4'h9
`define PCB_CMD_CFG_RD   4'ha
`define PCB_CMD_CFG_WR   4'hb
`define PCB_CMD_MEM_RDM  4'hc
`define PCB_CMD_DUAL     4'hd
`define PCB_CMD_MEM_RDL  4'he
`define PCB_CMD_MEM_WRI  4'hf

// ----------------------------------------------------------------------------
// Address-phase fields
// ----------------------------------------------------------------------------
`define PCB_ADDR_LOW_MSB  1
`define PCB_ADDR_LOW_LSB  0
`define PCB_BURST_LINEAR  2'h0
`define PCB_CFG_TYPE0     2'h0
`define PCB_CFG_TYPE1     2'h1
`define PCB_ALL_BYTES_N   4'h0
`define PCB_UPPER_ZERO    32'h0000_0000
`define PCB_ADDR_PHASES   1

`endif

// File: rtl/pcb_pkg.sv
// Shared types for the bridge command/address decoder and its initiator.
// Assumes pcb_regs.svh supplies all numeric codes.
package pcb_pkg;

  typedef logic [3:0]  pcb_cmd_type;
  typedef logic [63:0] pcb_addr64_type;

  // Initiator address-phase sequencer
  typedef enum logic [1:0] {
    PCB_ST_IDLE,
    PCB_ST_ADDR1,
    PCB_ST_ADDR2,
    PCB_ST_DATA
  } pcb_init_state_type;

endpackage

// File: rtl/pcb_bus_if.sv
// Shared bus carrier between the initiator end and the bridge decoder end.
// Assumes one clock; the testbench resolves wire levels from the enables.
`timescale 1ns/1ps
`default_nettype none

interface pcb_bus_if;
  logic        frame_n;     // Frame, active low
  logic        frame_oe_n;  // Frame output enable, low while driven
  logic [31:0] ad;          // Multiplexed address/data
  logic        ad_oe_n;     // Address/data output enable, low while driven
  logic [3:0]  cbe_n;       // Command / byte enables, active low
  logic        cbe_oe_n;    // Command output enable, low while driven

  modport initiator (
    output frame_n, frame_oe_n, ad, ad_oe_n, cbe_n, cbe_oe_n
  );
  modport bridge (
    input  frame_n, frame_oe_n, ad, ad_oe_n, cbe_n, cbe_oe_n
  );
endinterface

`default_nettype wire

// File: rtl/pcb_addr_capture.sv
// Address-phase capture: finds the first address phase and folds a dual
// address pair into one 64-bit address with its effective command.
// Assumes bus signals come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.svh"

module pcb_addr_capture (
  input  wire logic                    clock,       // 50 MHz clock
  input  wire logic                    reset_n,     // Async reset, active low
  input  wire logic                    frame_act,   // Frame driven and asserted
  input  wire logic [31:0]             ad,          // Address/data lines
  input  wire pcb_pkg::pcb_cmd_type    cmd,         // Command, true polarity
  output logic                         cap_valid,   // Address complete, one cycle
  output pcb_pkg::pcb_addr64_type      cap_addr,    // Full address
  output pcb_pkg::pcb_cmd_type         cap_cmd,     // Effective command
  output logic                         cap_dual     // Two address phases seen
);

  logic frame_prev_ff;
  logic wait_hi_ff;
  logic start;

  // --------------------------------------------------------------------------
  // First address phase detection
  // --------------------------------------------------------------------------
  assign start = frame_act && !frame_prev_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_prev_ff <= 1'b0;
    end else begin
      frame_prev_ff <= frame_act;
    end
  end

  // Second phase always expected on the very next clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_hi_ff <= 1'b0;
    end else begin
      wait_hi_ff <= start && (cmd == `PCB_CMD_DUAL);
    end
  end

  // --------------------------------------------------------------------------
  // Address and command registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cap_valid <= 1'b0;
      cap_addr  <= 64'h0;
      cap_cmd   <= 4'h0;
      cap_dual  <= 1'b0;
    end else begin
      cap_valid <= (start && (cmd != `PCB_CMD_DUAL)) || wait_hi_ff;
      if (start) begin
        cap_addr <= {32'h0000_0000, ad};
        cap_cmd  <= cmd;
        cap_dual <= 1'b0;
      end else if (wait_hi_ff) begin
        cap_addr <= {ad, cap_addr[31:0]};
        cap_cmd  <= cmd;
        cap_dual <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/pcb_initiator.sv
// Initiator end: drives one or two address phases and one data phase.
// Assumes the bridge end only observes the bus.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.svh"

module pcb_initiator (
  input  wire logic                   clock,      // 50 MHz clock
  input  wire logic                   reset_n,    // Async reset, active low
  pcb_bus_if.initiator                bus,        // Bus towards the bridge
  input  wire logic                   req_valid,  // Start a transaction
  output logic                        req_ready,  // Idle, request taken
  input  wire pcb_pkg::pcb_cmd_type   req_cmd,    // Command to issue
  input  wire pcb_pkg::pcb_addr64_type req_addr,  // Target address
  input  wire logic [31:0]            req_data,   // Data phase value
  output logic                        req_reject  // Refused request, one cycle
);

  pcb_pkg::pcb_init_state_type state_ff;
  pcb_pkg::pcb_init_state_type nxt_state;
  pcb_pkg::pcb_cmd_type        cmd_ff;
  pcb_pkg::pcb_addr64_type     addr_ff;
  logic [31:0]                 data_ff;
  logic                        dual_ff;
  logic                        need_dual;
  logic                        is_mem;
  logic                        take;

  // --------------------------------------------------------------------------
  // Request screening
  // --------------------------------------------------------------------------
  assign need_dual = (req_addr[63:32] != `PCB_UPPER_ZERO);
  assign is_mem    = (req_cmd == `PCB_CMD_MEM_RD) || (req_cmd == `PCB_CMD_MEM_WR) ||
                     (req_cmd == `PCB_CMD_MEM_RDM) || (req_cmd == `PCB_CMD_MEM_RDL) ||
                     (req_cmd == `PCB_CMD_MEM_WRI);
  assign req_ready = (state_ff == pcb_pkg::PCB_ST_IDLE);
  assign take      = req_valid && req_ready && (!need_dual || is_mem);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_reject <= 1'b0;
    end else begin
      req_reject <= req_valid && req_ready && need_dual && !is_mem;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ff  <= 4'h0;
      addr_ff <= 64'h0;
      data_ff <= 32'h0;
      dual_ff <= 1'b0;
    end else if (take) begin
      cmd_ff  <= req_cmd;
      addr_ff <= req_addr;
      data_ff <= req_data;
      dual_ff <= need_dual;
    end
  end

  // --------------------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pcb_pkg::PCB_ST_IDLE:  if (take) nxt_state = pcb_pkg::PCB_ST_ADDR1;
      pcb_pkg::PCB_ST_ADDR1: nxt_state = dual_ff ? pcb_pkg::PCB_ST_ADDR2 : pcb_pkg::PCB_ST_DATA;
      pcb_pkg::PCB_ST_ADDR2: nxt_state = pcb_pkg::PCB_ST_DATA;
      pcb_pkg::PCB_ST_DATA:  nxt_state = pcb_pkg::PCB_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= pcb_pkg::PCB_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pin drive per phase, one clock per address phase
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus.frame_n    <= 1'b1;
      bus.frame_oe_n <= 1'b1;
      bus.ad         <= 32'h0;
      bus.ad_oe_n    <= 1'b1;
      bus.cbe_n      <= 4'hf;
      bus.cbe_oe_n   <= 1'b1;
    end else begin
      bus.frame_n    <= !(nxt_state == pcb_pkg::PCB_ST_ADDR1 || nxt_state == pcb_pkg::PCB_ST_ADDR2);
      bus.frame_oe_n <= (nxt_state == pcb_pkg::PCB_ST_IDLE);
      bus.ad_oe_n    <= (nxt_state == pcb_pkg::PCB_ST_IDLE);
      bus.cbe_oe_n   <= (nxt_state == pcb_pkg::PCB_ST_IDLE);
      unique case (nxt_state)
        pcb_pkg::PCB_ST_ADDR1: begin
          bus.ad    <= (state_ff == pcb_pkg::PCB_ST_IDLE) ? req_addr[31:0] : addr_ff[31:0];
          bus.cbe_n <= ~((state_ff == pcb_pkg::PCB_ST_IDLE) ?
                         (need_dual ? `PCB_CMD_DUAL : req_cmd) : cmd_ff);
        end
        pcb_pkg::PCB_ST_ADDR2: begin
          bus.ad    <= addr_ff[63:32];
          bus.cbe_n <= ~cmd_ff;
        end
        pcb_pkg::PCB_ST_DATA: begin
          bus.ad    <= data_ff;
          bus.cbe_n <= `PCB_ALL_BYTES_N;
        end
        pcb_pkg::PCB_ST_IDLE: begin
          bus.ad    <= 32'h0;
          bus.cbe_n <= 4'hf;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: rtl/pcb_bridge_decode.sv
// Bridge end: screens bus commands as target and as master on either bus
// and routes dual address transactions against the prefetchable range.
// Assumes the bus comes from same-clock logic; range bounds are stable.
//
// What this block does
// - Interrupt acknowledge never issued, never claimed
// - Reserved commands never issued, never claimed
// - Special cycles issued, never claimed as target
// - Remote special cycles requested via type 1
// - I/O and memory read/write both directions
// - Read multiple, line, invalidate, dual supported
// - Config reads secondary out; type 1 writes
// - No type 0 configuration onto primary
// - One clock per phase, starts on frame
// - Single phase: address on AD, command on C/BE
// - Nonlinear burst order disconnects after first transfer
// - Second dual phase on the next clock
// - Dual: low address first, high second
// - Dual downstream only inside prefetchable range
// - Second dual phase carries memory commands only
// - Upper dual address half never zero
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.svh"

module pcb_bridge_decode (
  input  wire logic                    clock,          // 50 MHz clock
  input  wire logic                    reset_n,        // Async reset, active low
  pcb_bus_if.bridge                    bus,            // Observed bus
  input  wire logic                    on_secondary,   // Watched bus is secondary
  input  wire pcb_pkg::pcb_addr64_type pf_base,        // Prefetchable range base
  input  wire pcb_pkg::pcb_addr64_type pf_limit,       // Prefetchable range limit
  input  wire pcb_pkg::pcb_cmd_type    mst_cmd,        // Command to be issued
  input  wire logic                    mst_secondary,  // Issue onto secondary bus
  input  wire logic [1:0]              mst_cfg_type,   // Config type to issue
  output logic                         mst_allowed,    // Issue permitted
  output logic                         dec_valid,      // Decision ready, one cycle
  output logic                         dec_claim,      // Bridge claims cycle
  output logic                         dec_downstream, // Forward primary to secondary
  output logic                         dec_disconnect, // Stop after first transfer
  output logic                         dec_dual,       // Dual address seen
  output pcb_pkg::pcb_cmd_type         dec_cmd,        // Effective command
  output pcb_pkg::pcb_addr64_type      dec_addr        // Full address
);

  logic                    frame_act;
  logic                    cap_valid;
  pcb_pkg::pcb_addr64_type cap_addr;
  pcb_pkg::pcb_cmd_type    cap_cmd;
  logic                    cap_dual;
  logic                    tgt_ok;
  logic                    in_range;
  logic                    is_mem;
  logic                    claim;
  logic                    single_claim;
  logic                    dual_claim;
  logic [1:0]              low_bits;
  logic                    burst_linear;
  logic                    cfg_type1;
  logic                    above_base;
  logic                    below_limit;
  logic                    mst_cfg_ok;

  // --------------------------------------------------------------------------
  // Address capture
  // --------------------------------------------------------------------------
  assign frame_act = !bus.frame_oe_n && !bus.frame_n;

  pcb_addr_capture u_capture (
    .clock     (clock),
    .reset_n   (reset_n),
    .frame_act (frame_act),
    .ad        (bus.ad),
    .cmd       (~bus.cbe_n),
    .cap_valid (cap_valid),
    .cap_addr  (cap_addr),
    .cap_cmd   (cap_cmd),
    .cap_dual  (cap_dual)
  );

  // --------------------------------------------------------------------------
  // Address field decode
  // --------------------------------------------------------------------------
  // Low address bits select burst order or config type
  assign low_bits     = cap_addr[`PCB_ADDR_LOW_MSB:`PCB_ADDR_LOW_LSB];
  assign burst_linear = (low_bits == `PCB_BURST_LINEAR);
  assign cfg_type1    = (low_bits == `PCB_CFG_TYPE1);

  // --------------------------------------------------------------------------
  // Target acceptance per command and side
  // --------------------------------------------------------------------------
  // Memory commands that may stand in a second dual phase
  always_comb begin
    unique case (cap_cmd)
      `PCB_CMD_MEM_RD,
      `PCB_CMD_MEM_WR,
      `PCB_CMD_MEM_RDM,
      `PCB_CMD_MEM_RDL,
      `PCB_CMD_MEM_WRI: is_mem = 1'b1;
      default:          is_mem = 1'b0;
    endcase
  end

  always_comb begin
    tgt_ok = 1'b0;
    unique case (cap_cmd)
      `PCB_CMD_INTACK:  tgt_ok = 1'b0;
      `PCB_CMD_SPECIAL: tgt_ok = 1'b0;
      `PCB_CMD_RSV4:    tgt_ok = 1'b0;
      `PCB_CMD_RSV5:    tgt_ok = 1'b0;
      `PCB_CMD_RSV8:    tgt_ok = 1'b0;
      `PCB_CMD_RSV9:    tgt_ok = 1'b0;
      `PCB_CMD_IO_RD:   tgt_ok = 1'b1;
      `PCB_CMD_IO_WR:   tgt_ok = 1'b1;
      `PCB_CMD_MEM_RD:  tgt_ok = 1'b1;
      `PCB_CMD_MEM_WR:  tgt_ok = 1'b1;
      `PCB_CMD_MEM_RDM: tgt_ok = 1'b1;
      `PCB_CMD_MEM_RDL: tgt_ok = 1'b1;
      `PCB_CMD_MEM_WRI: tgt_ok = 1'b1;
      `PCB_CMD_CFG_RD:  tgt_ok = !on_secondary;
      `PCB_CMD_CFG_WR:  tgt_ok = !on_secondary || cfg_type1;
      `PCB_CMD_DUAL:    tgt_ok = 1'b0;  // Dual code in second phase is illegal
    endcase
  end

  // Range check uses the completed 64-bit address only
  assign above_base  = (cap_addr >= pf_base);
  assign below_limit = (cap_addr <= pf_limit);
  assign in_range    = above_base && below_limit;

  // --------------------------------------------------------------------------
  // Target claim
  // --------------------------------------------------------------------------
  // Single phase claims by command, dual by memory command and range side
  assign single_claim = tgt_ok;
  assign dual_claim   = is_mem && (on_secondary ? !in_range : in_range);

  // Dual result replaces the command-only result
  always_comb begin
    claim = single_claim;
    if (cap_dual) begin
      // Non-memory second phase is left to master abort
      claim = dual_claim;
    end
  end

  // --------------------------------------------------------------------------
  // Decision registers
  // --------------------------------------------------------------------------
  // Decision pulse one cycle after capture
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= cap_valid;
    end
  end

  // Decision fields hold until the next decision
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dec_claim      <= 1'b0;
      dec_downstream <= 1'b0;
      dec_disconnect <= 1'b0;
      dec_dual       <= 1'b0;
      dec_cmd        <= 4'h0;
      dec_addr       <= 64'h0;
    end else if (cap_valid) begin
      dec_claim      <= claim;
      dec_downstream <= claim && !on_secondary;
      dec_disconnect <= claim && is_mem &&
                        !burst_linear;
      dec_dual       <= cap_dual;
      dec_cmd        <= cap_cmd;
      dec_addr       <= cap_addr;
    end
  end

  // --------------------------------------------------------------------------
  // Master issue screening
  // --------------------------------------------------------------------------
  // Primary config writes only in type 1 form
  assign mst_cfg_ok = mst_secondary || (mst_cfg_type == `PCB_CFG_TYPE1);

  // Issue permission per command and bus
  always_comb begin
    mst_allowed = 1'b0;
    unique case (mst_cmd)
      `PCB_CMD_INTACK:  mst_allowed = 1'b0;
      `PCB_CMD_RSV4:    mst_allowed = 1'b0;
      `PCB_CMD_RSV5:    mst_allowed = 1'b0;
      `PCB_CMD_RSV8:    mst_allowed = 1'b0;
      `PCB_CMD_RSV9:    mst_allowed = 1'b0;
      `PCB_CMD_SPECIAL: mst_allowed = 1'b1;
      `PCB_CMD_IO_RD:   mst_allowed = 1'b1;
      `PCB_CMD_IO_WR:   mst_allowed = 1'b1;
      `PCB_CMD_MEM_RD:  mst_allowed = 1'b1;
      `PCB_CMD_MEM_WR:  mst_allowed = 1'b1;
      `PCB_CMD_MEM_RDM: mst_allowed = 1'b1;
      `PCB_CMD_MEM_RDL: mst_allowed = 1'b1;
      `PCB_CMD_MEM_WRI: mst_allowed = 1'b1;
      `PCB_CMD_DUAL:    mst_allowed = 1'b1;
      `PCB_CMD_CFG_RD:  mst_allowed = mst_secondary;
      `PCB_CMD_CFG_WR:  mst_allowed = mst_cfg_ok;
    endcase
  end

endmodule

`default_nettype wire

// File: tb/pcb_bus_sva.sv
// Checker for the shared bus between the initiator end and the bridge end.
// Assumes the testbench instantiates it beside the interface, on one clock.
`timescale 1ns/1ps
`default_nettype none

module pcb_bus_sva (
  input wire logic        clock,      // 50 MHz clock
  input wire logic        reset_n,    // Async reset, active low
  input wire logic        frame_n,    // Frame, active low
  input wire logic        frame_oe_n, // Frame enable, low while driven
  input wire logic [31:0] ad,         // Address/data
  input wire logic        ad_oe_n,    // Address/data enable
  input wire logic [3:0]  cbe_n,      // Command / byte enables
  input wire logic        cbe_oe_n,   // Command enable
  input wire logic [3:0]  mst_cmd,    // Command the bridge would issue
  input wire logic        mst_allowed // Bridge issue permission
);
  // ---------------------------------------------------------------------------
  // Issue-permission, address-phase and data-phase properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_no_intack_issue: assert property (mst_cmd == 4'h0 |-> !mst_allowed)
    else $error("interrupt acknowledge issue permitted");
  a_no_reserved_issue: assert property (mst_cmd inside {4'h4, 4'h5, 4'h8, 4'h9} |-> !mst_allowed)
    else $error("reserved command issue permitted");
  a_single_one_phase: assert property ($fell(frame_n) && ~cbe_n != 4'hd |=> frame_n)
    else $error("single address phase longer than one clock");
  a_dual_next_clock: assert property ($fell(frame_n) && ~cbe_n == 4'hd |=> !frame_n && !frame_oe_n ##1 frame_n)
    else $error("second dual phase misplaced");
  a_dual_upper_set: assert property ($fell(frame_n) && ~cbe_n == 4'hd |=> ad != 32'h0000_0000)
    else $error("dual upper half zero");
  a_dual_mem_cmd: assert property ($fell(frame_n) && ~cbe_n == 4'hd |=> (~cbe_n) inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf})
    else $error("second dual phase not a memory command");
  a_phase_driven: assert property (!frame_n |-> !frame_oe_n && !ad_oe_n && !cbe_oe_n)
    else $error("address phase not fully driven");
  a_data_follows: assert property ($rose(frame_n) |-> !ad_oe_n && cbe_n == 4'h0 ##1 frame_oe_n && ad_oe_n)
    else $error("data phase or release wrong");
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench: initiator end drives the bridge end through the bus.
// Assumes the design files and pcb_bus_sva are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_regs.svh"

module testbench;
  typedef struct {logic rej, claim, down, disc, dual; logic [3:0] cmd; logic [63:0] addr;} pcb_note_type;
  logic clock, reset_n, req_valid, req_ready, req_reject, on_secondary, mst_secondary, mst_allowed;
  logic dec_valid, dec_claim, dec_downstream, dec_disconnect, dec_dual;
  logic [1:0] mst_cfg_type;
  logic [3:0] req_cmd, mst_cmd, dec_cmd;
  logic [63:0] req_addr, dec_addr;
  logic [31:0] req_data, rnd;
  int errors, compares;
  pcb_note_type notes[$];
  pcb_note_type got;
  localparam logic [63:0] PF_BASE = 64'h0000_0010_0000_0000;
  localparam logic [63:0] PF_LIM  = 64'h0000_001f_ffff_ffff;
  logic [63:0] bd[4] = '{PF_BASE, PF_LIM, PF_BASE - 64'h1, PF_LIM + 64'h1};
  logic [3:0] mc[5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};
  logic [3:0] nm[5] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb};

  // ---------------------------------------------------------------------------
  // Both ends and the checker
  // ---------------------------------------------------------------------------
  pcb_bus_if pcb_bus_if_i ();
  pcb_initiator pcb_initiator_i (.clock(clock), .reset_n(reset_n), .bus(pcb_bus_if_i), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .req_reject(req_reject));
  pcb_bridge_decode pcb_bridge_decode_i (.clock(clock), .reset_n(reset_n), .bus(pcb_bus_if_i),
    .on_secondary(on_secondary), .pf_base(PF_BASE), .pf_limit(PF_LIM), .mst_cmd(mst_cmd),
    .mst_secondary(mst_secondary), .mst_cfg_type(mst_cfg_type), .mst_allowed(mst_allowed),
    .dec_valid(dec_valid), .dec_claim(dec_claim), .dec_downstream(dec_downstream),
    .dec_disconnect(dec_disconnect), .dec_dual(dec_dual), .dec_cmd(dec_cmd), .dec_addr(dec_addr));
  pcb_bus_sva pcb_bus_sva_i (.clock(clock), .reset_n(reset_n), .frame_n(pcb_bus_if_i.frame_n),
    .frame_oe_n(pcb_bus_if_i.frame_oe_n), .ad(pcb_bus_if_i.ad), .ad_oe_n(pcb_bus_if_i.ad_oe_n),
    .cbe_n(pcb_bus_if_i.cbe_n), .cbe_oe_n(pcb_bus_if_i.cbe_oe_n), .mst_cmd(mst_cmd), .mst_allowed(mst_allowed));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare one value
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Next pseudo-random word
  function automatic void step();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endfunction

  // Note the expected decision, then issue one request
  task automatic send(input logic [3:0] c, input logic [63:0] a, input logic s);
    pcb_note_type n;
    logic mem, inr;
    mem = c inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    inr = a >= PF_BASE && a <= PF_LIM;
    case (c)
      4'h2, 4'h3, 4'h6, 4'h7, 4'hc, 4'he, 4'hf: n.claim = 1'b1;
      4'ha: n.claim = !s;
      4'hb: n.claim = !s || a[1:0] == 2'h1;
      default: n.claim = 1'b0;
    endcase
    n.dual = a[63:32] != 32'h0000_0000;
    if (n.dual)
      n.claim = mem && (s ? !inr : inr);
    n.rej = n.dual && !mem;
    n.down = n.claim && !s;
    n.disc = n.claim && mem && a[1:0] != 2'h0;
    n.cmd = c;
    n.addr = a;
    notes.push_back(n);
    step();
    on_secondary = s;
    req_cmd = c;
    req_addr = a;
    req_data = rnd;
    req_valid = 1'b1;
    @(posedge clock);
    #1 req_valid = 1'b0;
    do begin
      @(posedge clock);
      #1;
    end while (req_ready !== 1'b1);
  endtask

  // ---------------------------------------------------------------------------
  // Result watcher: oldest note against each decision or refusal
  // ---------------------------------------------------------------------------
  always @(negedge clock) begin
    if (reset_n === 1'b1 && (dec_valid === 1'b1 || req_reject === 1'b1)) begin
      if (notes.size() == 0)
        check("note_queue", 64'h0, 64'h1);
      else begin
        got = notes.pop_front();
        check("req_reject", req_reject, got.rej);
        if (!got.rej) begin
          check("dec_claim", dec_claim, got.claim);
          check("dec_downstream", dec_downstream, got.down);
          check("dec_disconnect", dec_disconnect, got.disc);
          check("dec_dual", dec_dual, got.dual);
          check("dec_cmd", dec_cmd, got.cmd);
          check("dec_addr", dec_addr, got.addr);
        end
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    rnd = 32'h5eff;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_addr = 64'h0;
    req_data = 32'h0;
    on_secondary = 1'b0;
    mst_cmd = 4'h0;
    mst_secondary = 1'b0;
    mst_cfg_type = 2'h0;
    repeat (12) @(posedge clock);
    #1 reset_n = 1'b1;
    // Master permission table over every command and bus, config types 0 and 1
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      #1 mst_cmd = i[3:0];
      mst_secondary = i[4];
      mst_cfg_type = {1'b0, i[5]};
      #5;
      case (i[3:0])
        4'h0, 4'h4, 4'h5, 4'h8, 4'h9: check("mst_allowed", mst_allowed, 64'h0);
        4'ha: check("mst_allowed", mst_allowed, {63'h0, i[4]});
        4'hb: check("mst_allowed", mst_allowed, {63'h0, i[4] | i[5]});
        default: check("mst_allowed", mst_allowed, 64'h1);
      endcase
    end
    @(posedge clock);
    #1;
    // Single address phases, every command but dual and every low-bit pattern, both buses
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 16; c++)
        for (int k = 0; k < 4; k++)
          if (c != 13) begin
            step();
            send(c[3:0], {32'h0, rnd[31:2], k[1:0]}, s[0]);
          end
    // Dual address phases at the range edges, both buses
    for (int s = 0; s < 2; s++)
      for (int j = 0; j < 5; j++)
        for (int b = 0; b < 4; b++)
          send(mc[j], bd[b], s[0]);
    // Dual address with non-memory commands is refused
    foreach (nm[j]) begin
      step();
      send(nm[j], {rnd | 32'h1, rnd}, j[0]);
    end
    repeat (8) @(posedge clock);
    check("notes_left", notes.size(), 64'h0);
    complete_run();
  end
endmodule

`default_nettype wire
